// ==== design/ivpr_pkg.sv ====
// Purpose: Shared constants for the interrupt vector priority resolver
// Assumes: APB register window with 32-bit data, byte addresses below 8'h20
// Notes: Vector numbers index a 64-entry request space; unused entries stay zero
package ivpr_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_PRIO_A = 8'h00;
  localparam logic [7:0] OFS_PRIO_B = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_EVT_STAT = 8'h0c;
  localparam logic [7:0] OFS_EVT_MASK = 8'h10;

  // Values after reset
  localparam logic [7:0] RST_PRIO = 8'h00;
  localparam logic [1:0] RST_EVT = 2'h0;

  // Vector numbers of the first source in each run
  localparam int VEC_NMI = 7;
  localparam int VEC_IRQ0 = 12;
  localparam int VEC_WDT = 20;
  localparam int VEC_REFRESH = 21;
  localparam int VEC_TIMER0 = 24;
  localparam int VEC_DMA0 = 44;
  localparam int VEC_SER0 = 52;
  localparam int VEC_SER1 = 56;
  localparam int VEC_ADC = 60;
  localparam int TIMER_STRIDE = 4;
  localparam int TIMER_CHANNELS = 5;
  localparam int SER_SOURCES = 4;

  // Each table entry is four bytes wide
  localparam int VEC_ADDR_SHIFT = 2;

  // Group priority bit positions in word A
  localparam int PA_IRQ0 = 7;
  localparam int PA_IRQ1 = 6;
  localparam int PA_IRQ23 = 5;
  localparam int PA_IRQ45 = 4;
  localparam int PA_WDT_REF = 3;
  localparam int PA_TIMER0 = 2;

  // Group priority bit positions in word B
  localparam int PB_TIMER3 = 7;
  localparam int PB_DMA = 5;
  localparam int PB_SER0 = 3;
  localparam int PB_SER1 = 2;
  localparam int PB_ADC = 1;

  // Result register fields
  localparam int RES_LVL_BIT = 6;
  localparam int RES_VALID_BIT = 7;
  localparam int RES_ADDR_LSB = 16;

  // Event status bits
  localparam int EVT_NEW_WIN = 0;
  localparam int EVT_NMI = 1;

  // Pin synchroniser depth
  localparam int SYNC_STAGES = 3;

endpackage

// ==== design/ivpr_pin_sync.sv ====
// Purpose: Bring asynchronous request pins into the MCLK domain
// Assumes: Pins are level signals, active high after board inversion
// Notes: The filtered value only moves once the second and third stages agree
`timescale 1ns/1ps
module ivpr_pin_sync
  import ivpr_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SRST,
  // Pins and filtered result
  input wire logic [WIDTH-1:0] PIN_IN,
  output logic [WIDTH-1:0] PIN_OUT
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] out_d;

  // Keep the old value where the late stages disagree, which hides one-cycle glitches
  assign out_d = (s2_q & s3_q) | (out_q & (s2_q ^ s3_q));
  assign PIN_OUT = out_q;

  // Three-stage chain; the first stage feeds only the second
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= PIN_IN;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

endmodule

// ==== design/ivpr_top.sv ====
// Purpose: Rank pending interrupt requests and hand one vector to the CPU core
// Assumes: Requests are active-high levels already gated by their own enables
// Notes: One cycle from an on-chip request to the registered vector outputs; pin requests take five through the synchroniser
// Functional notes
// - With default order, lower vector number beats any higher one.
// - Nonmaskable request is always top and ignores the priority words.
// - After reset all group bits are zero, giving the default order.
// - Table entry is four bytes at four times the vector; 16 address bits.
// - Nonmaskable uses 7, pin requests 0..5 use 12..17, 18-19 reserved.
// - Watchdog 20, refresh 21, timer n uses 24+4n, 25+4n, 26+4n.
// - DMA ends use 44..47, 48..51 reserved, converter done uses 60.
// - Serial channel 0 uses 52..55, channel 1 uses 56..59, fixed order.
// - Priority bits are shared per source group as listed.
// - Group bit one ranks above every group bit zero.
// - Equal levels fall back to the vector-number order.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module ivpr_top
  import ivpr_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic SRST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Pin requests
  input wire logic NMI_REQ,
  input wire logic [5:0] IRQ_REQ,
  // On-chip requests
  input wire logic WATCHDOG_INTERVAL_REQ,
  input wire logic REFRESH_COMPARE_REQ,
  input wire logic [14:0] TIMER_REQ,
  input wire logic [3:0] DMA_END_REQ,
  input wire logic [7:0] SERIAL_REQ,
  input wire logic CONVERTER_DONE_REQ,
  // To the CPU core
  output logic [5:0] VEC_NUM,
  output logic VEC_LEVEL,
  output logic VEC_VALID,
  output logic [15:0] VEC_ADDR,
  // Event interrupt
  output logic IRQ_OUT
);

  logic [6:0] pin_sync;
  logic [63:0] req_vec;
  logic [63:0] lvl_vec;
  logic [63:0] hi_vec;
  logic [4:0] timer_lvl;
  logic [5:0] win_d;
  logic lvl_d;
  logic valid_d;
  logic [7:0] group_priority_word_a_q;
  logic [7:0] group_priority_word_b_q;
  logic [5:0] vec_q;
  logic lvl_q;
  logic valid_q;
  logic [15:0] addr_q;
  logic nmi_prev_q;
  logic [1:0] evt_stat_q;
  logic [1:0] evt_stat_d;
  logic [1:0] evt_mask_q;
  logic [1:0] evt_set;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  logic setup_ph;
  logic wr_en;
  logic addr_hit;
  logic hit_a;
  logic hit_b;
  logic hit_res;
  logic hit_stat;
  logic hit_mask;

  // Lowest set index, so lower vector numbers win ties
  function automatic logic [5:0] first_set(input logic [63:0] v);
    logic [5:0] idx;
    idx = 6'h00;
    for (int i = 63; i >= 0; i--) begin
      if (v[i]) begin
        idx = 6'(i);
      end
    end
    return idx;
  endfunction

  // Pins cross from outside the clock domain
  ivpr_pin_sync #(
    .WIDTH(7)
  ) u_pin_sync (
    .MCLK(MCLK),
    .SRST(SRST),
    .PIN_IN({IRQ_REQ, NMI_REQ}),
    .PIN_OUT(pin_sync)
  );

  // Place each source at its vector number
  always_comb begin
    req_vec = '0;
    req_vec[VEC_NMI] = pin_sync[0];
    for (int k = 0; k < 6; k++) begin
      req_vec[VEC_IRQ0 + k] = pin_sync[k + 1];
    end
    req_vec[VEC_WDT] = WATCHDOG_INTERVAL_REQ;
    req_vec[VEC_REFRESH] = REFRESH_COMPARE_REQ;
    for (int n = 0; n < TIMER_CHANNELS; n++) begin
      for (int k = 0; k < 3; k++) begin
        req_vec[VEC_TIMER0 + TIMER_STRIDE * n + k] = TIMER_REQ[3 * n + k];
      end
    end
    for (int k = 0; k < 4; k++) begin
      req_vec[VEC_DMA0 + k] = DMA_END_REQ[k];
    end
    for (int k = 0; k < SER_SOURCES; k++) begin
      req_vec[VEC_SER0 + k] = SERIAL_REQ[k];
      req_vec[VEC_SER1 + k] = SERIAL_REQ[SER_SOURCES + k];
    end
    req_vec[VEC_ADC] = CONVERTER_DONE_REQ;
  end

  // Timer channel group bits, 0..2 from word A and 3..4 from word B; a fixed list keeps every index in range
  assign timer_lvl = {group_priority_word_b_q[PB_TIMER3 - 1], group_priority_word_b_q[PB_TIMER3],
    group_priority_word_a_q[PA_TIMER0 - 2], group_priority_word_a_q[PA_TIMER0 - 1],
    group_priority_word_a_q[PA_TIMER0]};

  // Spread the shared group bits over their vectors; the nonmaskable entry has none
  always_comb begin
    lvl_vec = '0;
    lvl_vec[VEC_IRQ0] = group_priority_word_a_q[PA_IRQ0];
    lvl_vec[VEC_IRQ0 + 1] = group_priority_word_a_q[PA_IRQ1];
    for (int k = 2; k < 4; k++) begin
      lvl_vec[VEC_IRQ0 + k] = group_priority_word_a_q[PA_IRQ23];
      lvl_vec[VEC_IRQ0 + k + 2] = group_priority_word_a_q[PA_IRQ45];
    end
    lvl_vec[VEC_WDT] = group_priority_word_a_q[PA_WDT_REF];
    lvl_vec[VEC_REFRESH] = group_priority_word_a_q[PA_WDT_REF];
    for (int n = 0; n < TIMER_CHANNELS; n++) begin
      for (int k = 0; k < 3; k++) begin
        lvl_vec[VEC_TIMER0 + TIMER_STRIDE * n + k] = timer_lvl[n];
      end
    end
    for (int k = 0; k < 4; k++) begin
      lvl_vec[VEC_DMA0 + k] = group_priority_word_b_q[PB_DMA];
      lvl_vec[VEC_SER0 + k] = group_priority_word_b_q[PB_SER0];
      lvl_vec[VEC_SER1 + k] = group_priority_word_b_q[PB_SER1];
    end
    lvl_vec[VEC_ADC] = group_priority_word_b_q[PB_ADC];
  end

  // Two levels below the nonmaskable request; ties go by vector number
  assign hi_vec = req_vec & lvl_vec;
  assign valid_d = |req_vec;
  assign win_d = req_vec[VEC_NMI] ? 6'(VEC_NMI) :
    (|hi_vec) ? first_set(hi_vec) : first_set(req_vec);
  assign lvl_d = req_vec[VEC_NMI] | (|hi_vec);

  // Winner is registered so the core sees a stable vector for a whole cycle
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      vec_q <= 6'h00;
      lvl_q <= 1'b0;
      valid_q <= 1'b0;
      addr_q <= 16'h0000;
    end else begin
      vec_q <= win_d;
      lvl_q <= lvl_d;
      valid_q <= valid_d;
      addr_q <= {8'h00, win_d, 2'b00};
    end
  end

  assign VEC_NUM = vec_q;
  assign VEC_LEVEL = lvl_q;
  assign VEC_VALID = valid_q;
  assign VEC_ADDR = addr_q;

  // APB decode; zero wait states, unmapped addresses answer with an error
  assign setup_ph = PSEL & ~PENABLE;
  assign hit_a = (PADDR == OFS_PRIO_A);
  assign hit_b = (PADDR == OFS_PRIO_B);
  assign hit_res = (PADDR == OFS_RESULT);
  assign hit_stat = (PADDR == OFS_EVT_STAT);
  assign hit_mask = (PADDR == OFS_EVT_MASK);
  assign addr_hit = hit_a | hit_b | hit_res | hit_stat | hit_mask;
  assign wr_en = PSEL & PENABLE & PWRITE & addr_hit;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~addr_hit;

  // Read data is captured in the setup phase so it comes from a flop
  assign rd_mux = hit_a ? {24'h000000, group_priority_word_a_q} :
    hit_b ? {24'h000000, group_priority_word_b_q} :
    hit_res ? {addr_q, 8'h00, valid_q, lvl_q, vec_q} :
    hit_stat ? {30'h0, evt_stat_q} :
    hit_mask ? {30'h0, evt_mask_q} : 32'h00000000;
  assign PRDATA = prdata_q;

  // Events: a new winner appears, or the nonmaskable request rises
  assign evt_set[EVT_NEW_WIN] = valid_d & (~valid_q | (win_d != vec_q));
  assign evt_set[EVT_NMI] = pin_sync[0] & ~nmi_prev_q;
  // Setting beats a write-one clear in the same cycle
  assign evt_stat_d = (evt_stat_q & ~((wr_en & hit_stat) ? PWDATA[1:0] : 2'h0)) | evt_set;
  assign IRQ_OUT = |(evt_stat_q & evt_mask_q);

  // Priority words reset to the default order
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      group_priority_word_a_q <= RST_PRIO;
      group_priority_word_b_q <= RST_PRIO;
    end else if (wr_en) begin
      if (hit_a) begin
        group_priority_word_a_q <= PWDATA[7:0];
      end
      if (hit_b) begin
        group_priority_word_b_q <= PWDATA[7:0];
      end
    end
  end

  // Event status, mask and read capture
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      evt_stat_q <= RST_EVT;
      evt_mask_q <= RST_EVT;
      nmi_prev_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      evt_stat_q <= evt_stat_d;
      nmi_prev_q <= pin_sync[0];
      if (wr_en & hit_mask) begin
        evt_mask_q <= PWDATA[1:0];
      end
      if (setup_ph & ~PWRITE) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // Helper copies of the ranked inputs, read only by the checks below
  logic [63:0] chk_req_q;
  logic [63:0] chk_lvl_q;
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      chk_req_q <= '0;
      chk_lvl_q <= '0;
    end else begin
      chk_req_q <= req_vec;
      chk_lvl_q <= lvl_vec;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);

  // Ranking checks; the helper copies line the inputs up with the registered winner
  a_default_lower_wins: assert property (VEC_VALID && !chk_req_q[VEC_NMI] && !chk_lvl_q[VEC_NUM] |->
    (chk_req_q & ((64'h1 << VEC_NUM) - 64'h1)) == 64'h0)
    else $error("Lower vector pending but not chosen");
  a_nmi_top_rank: assert property (req_vec[VEC_NMI] |=> VEC_NUM == 6'h07 && VEC_LEVEL)
    else $error("Nonmaskable request lost top rank");
  a_reset_default: assert property ($past(SRST) |-> group_priority_word_a_q == 8'h00 &&
    group_priority_word_b_q == 8'h00)
    else $error("Priority words not default after reset");
  // Vector placement, table address, group sharing and ranking by level
  a_table_address: assert property (VEC_ADDR == {8'h00, VEC_NUM, 2'b00})
    else $error("Vector address not four times the vector");
  a_pin_vector: assert property (req_vec == 64'h0000_0000_0002_0000 |=> VEC_NUM == 6'h11)
    else $error("Pin request 5 not on vector 17");
  a_timer_vector: assert property (TIMER_REQ == 15'h4000 && $stable(TIMER_REQ) && req_vec == $past(req_vec)
    ##0 req_vec == 64'h0000_0400_0000_0000 |=> VEC_NUM == 6'h2a)
    else $error("Timer 4 overflow not on vector 42");
  a_dma_vector: assert property (req_vec == 64'h0000_8000_0000_0000 |=> VEC_NUM == 6'h2f)
    else $error("DMA channel 1B end not on vector 47");
  a_serial_vector: assert property (req_vec == 64'h0080_0000_0000_0000 |=> VEC_NUM == 6'h37)
    else $error("Serial 0 transmit end not on vector 55");
  a_group_shared: assert property (lvl_vec[14] == lvl_vec[15] && lvl_vec[14] == group_priority_word_a_q[5] &&
    lvl_vec[40] == group_priority_word_b_q[6] && lvl_vec[7] == 1'b0)
    else $error("Group bit sharing broken");
  a_high_level_first: assert property (VEC_VALID && |(chk_req_q & chk_lvl_q) |-> VEC_LEVEL &&
    (chk_req_q[VEC_NUM] && (chk_lvl_q[VEC_NUM] || VEC_NUM == 6'h07)))
    else $error("Level one request not ranked first");
  a_equal_level_order: assert property (VEC_VALID && chk_lvl_q[VEC_NUM] && !chk_req_q[VEC_NMI] |->
    (chk_req_q & chk_lvl_q & ((64'h1 << VEC_NUM) - 64'h1)) == 64'h0)
    else $error("Equal level tie not by vector order");
  a_valid_follows: assert property ((|req_vec) |=> VEC_VALID ##0 chk_req_q[VEC_NUM])
    else $error("Pending request not presented");
  // Level and idle behaviour of the presented winner
  a_level_matches: assert property (VEC_VALID && VEC_NUM != 6'(VEC_NMI) |-> VEC_LEVEL == chk_lvl_q[VEC_NUM])
    else $error("Winner level differs from its group bit");
  a_idle_not_valid: assert property (!(|req_vec) |=> !VEC_VALID)
    else $error("Valid shown with nothing pending");

  // Main scenarios
  c_nmi_over_high: cover property (req_vec[VEC_NMI] && |hi_vec ##1 VEC_NUM == 6'h07);
  c_default_tie: cover property (VEC_VALID && !VEC_LEVEL && $countones(chk_req_q) > 1);
  c_high_preempts: cover property (VEC_VALID && VEC_LEVEL && chk_req_q[12] && VEC_NUM > 6'h0c);
  c_irq_raised: cover property (!IRQ_OUT ##1 IRQ_OUT);
  c_prio_write: cover property (wr_en && hit_b && PWDATA[7:0] != 8'h00);

endmodule

// ==== dv/ivpr_cpu_model.sv ====
// Purpose: Behavioural CPU core that fetches the vector the resolver offers
// Assumes: The core fetches on every edge where a valid winner is shown
// Notes: Only the table address is used, so a wrong address shows as a wrong vector
`timescale 1ns/1ps
module ivpr_cpu_model
  import ivpr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Offered vector
  input wire logic vec_valid,
  input wire logic [15:0] vec_addr,
  // Entry index the core fetched last
  output logic [5:0] taken_vec_q
);
  // Entries are four bytes wide, so the index is the address over four
  always_ff @(posedge mclk) begin
    if (srst) begin
      taken_vec_q <= 6'h00;
    end else if (vec_valid) begin
      taken_vec_q <= vec_addr[7:2];
    end
  end
endmodule

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench for the vector priority resolver
// Assumes: Pins settle at the vector outputs five edges after a change
// Notes: Random request patterns and priority words use a fixed seed
`timescale 1ns/1ps
module testbench;
  import ivpr_pkg::*;
  // Vector numbers that have a real source behind them
  localparam logic [63:0] SRC = 64'h1ff0f777_7733f080;
  logic MCLK = 1'b0;
  logic SRST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h00000000;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, VEC_LEVEL, VEC_VALID, IRQ_OUT, err;
  logic [5:0] VEC_NUM, taken_vec;
  logic [15:0] VEC_ADDR;
  logic [63:0] req = 64'h0;
  logic [31:0] rd;
  logic [79:0] corner [4];
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 66;

  // 125 MHz system clock
  always #4 MCLK = ~MCLK;

  // Requests are held by vector number and spread over the source ports
  ivpr_top DUT (.MCLK(MCLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .NMI_REQ(req[7]), .IRQ_REQ(req[17:12]), .WATCHDOG_INTERVAL_REQ(req[20]),
    .REFRESH_COMPARE_REQ(req[21]),
    .TIMER_REQ({req[42:40], req[38:36], req[34:32], req[30:28], req[26:24]}),
    .DMA_END_REQ(req[47:44]), .SERIAL_REQ(req[59:52]), .CONVERTER_DONE_REQ(req[60]),
    .VEC_NUM(VEC_NUM), .VEC_LEVEL(VEC_LEVEL), .VEC_VALID(VEC_VALID), .VEC_ADDR(VEC_ADDR),
    .IRQ_OUT(IRQ_OUT));

  ivpr_cpu_model CPU (.mclk(MCLK), .srst(SRST), .vec_valid(VEC_VALID), .vec_addr(VEC_ADDR),
    .taken_vec_q(taken_vec));

  // Group bit that steers a vector
  function automatic logic grp(int v, logic [7:0] a, logic [7:0] b);
    if (v < 12) return 1'b0;
    if (v < 14) return a[19 - v];
    if (v < 16) return a[5];
    if (v < 18) return a[4];
    if (v < 24) return a[3];
    if (v < 36) return a[2 - (v - 24) / 4];
    if (v < 44) return b[7 - (v - 36) / 4];
    if (v < 48) return b[5];
    if (v < 56) return b[3];
    if (v < 60) return b[2];
    return b[1];
  endfunction

  // Expected winner as valid, level, vector
  function automatic logic [7:0] pick(logic [63:0] m, logic [7:0] a, logic [7:0] b);
    logic [7:0] w0, w1;
    w0 = 8'h00;
    w1 = 8'h00;
    // Walking down leaves the lowest vector of each level
    for (int v = 63; v >= 0; v--) begin
      if (m[v] && grp(v, a, b)) w1 = {2'b11, 6'(v)};
      else if (m[v]) w0 = {2'b10, 6'(v)};
    end
    if (m[7]) return 8'hc7;
    return w1[7] ? w1 : w0;
  endfunction

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One APB transfer; request held until PREADY is seen high
  task automatic apb(logic wr, logic [7:0] addr, logic [31:0] wdata);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= addr;
    PWDATA <= wdata;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do @(posedge MCLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // Seven edges cover the pin synchroniser and the output register
  task automatic drive(logic [63:0] m);
    @(posedge MCLK);
    req <= m & SRC;
    repeat (7) @(posedge MCLK);
    #1;
  endtask

  // Set both priority words, apply requests, compare winner and result word
  task automatic run_case(logic [7:0] a, logic [7:0] b, logic [63:0] m);
    logic [7:0] w;
    apb(1'b1, OFS_PRIO_A, {24'h0, a});
    apb(1'b1, OFS_PRIO_B, {24'h0, b});
    drive(m);
    w = pick(m & SRC, a, b);
    check("vector valid", w[7], VEC_VALID);
    if (w[7]) begin
      check("vector number", w[5:0], VEC_NUM);
      check("vector level", w[6], VEC_LEVEL);
      check("vector address", {8'h00, w[5:0], 2'b00}, VEC_ADDR);
      check("fetched vector", w[5:0], taken_vec);
      apb(1'b0, OFS_RESULT, 32'h0);
      check("result word", {8'h00, w[5:0], 2'b00, 8'h00, w}, rd);
    end
    apb(1'b0, OFS_PRIO_B, 32'h0);
    check("word b readback", {24'h0, b}, rd);
  endtask

  // Hang guard, far above the few thousand cycles the tests need
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      $display("unexpected timeout: expected finish seen hang");
      tally_and_finish();
    end
  end

  initial begin
    corner[0] = {8'h20, 8'h00, 64'h0000_0000_0000_9000};
    corner[1] = {8'h00, 8'h02, 64'h1000_0000_0030_0000};
    corner[2] = {8'hff, 8'hff, 64'h1000_0000_0030_0080};
    corner[3] = {8'h01, 8'h00, 64'h0000_0001_0100_1000};
    repeat (12) @(posedge MCLK);
    SRST <= 1'b0;
    // Every register reads zero after reset
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check("reset value", 32'h0, rd);
    end
    check("valid after reset", 1'b0, VEC_VALID);
    $display("test reset values done");
    // Each source alone gives its own vector
    for (int v = 0; v < 64; v++) begin
      if (SRC[v]) run_case(8'h00, 8'h00, 64'h1 << v);
    end
    $display("test single sources done");
    // Shared group bits, level split and the nonmaskable override
    for (int i = 0; i < 4; i++) run_case(corner[i][79:72], corner[i][71:64], corner[i][63:0]);
    $display("test corner cases done");
    // Random patterns, the first ones under the default order
    for (int i = 0; i < 60; i++) begin
      run_case(i < 10 ? 8'h00 : 8'($random(seed)), i < 10 ? 8'h00 : 8'($random(seed)),
        {$random(seed), $random(seed)} & {$random(seed), $random(seed)});
    end
    $display("test random patterns done");
    // Event status, mask and interrupt output
    drive(64'h0);
    apb(1'b1, OFS_EVT_STAT, 32'h3);
    apb(1'b1, OFS_EVT_MASK, 32'h0);
    drive(64'h1 << 47);
    check("masked interrupt", 1'b0, IRQ_OUT);
    apb(1'b0, OFS_EVT_STAT, 32'h0);
    check("new winner event", 32'h1, rd);
    apb(1'b1, OFS_EVT_MASK, 32'h1);
    #1;
    check("interrupt raised", 1'b1, IRQ_OUT);
    apb(1'b1, OFS_EVT_STAT, 32'h1);
    #1;
    check("interrupt cleared", 1'b0, IRQ_OUT);
    drive((64'h1 << 7) | (64'h1 << 47));
    apb(1'b0, OFS_EVT_STAT, 32'h0);
    check("nonmaskable event", 32'h3, rd);
    apb(1'b1, OFS_EVT_MASK, 32'h2);
    #1;
    check("nonmaskable interrupt", 1'b1, IRQ_OUT);
    apb(1'b1, OFS_EVT_STAT, 32'h2);
    #1;
    check("nonmaskable cleared", 1'b0, IRQ_OUT);
    $display("test event interrupt done");
    // Unmapped address errors and reads zero
    apb(1'b1, 8'h14, 32'hffffffff);
    check("write error", 1'b1, err);
    apb(1'b0, 8'h14, 32'h0);
    check("read error", 1'b1, err);
    check("unmapped data", 32'h0, rd);
    $display("test unmapped address done");
    tally_and_finish();
  end
endmodule
